// [common/weld_seq_pkg.sv]
// Constants shared by the weld wait-hold sequencer and its pin filter.
// Assumes a single 250 MHz core clock and pins filtered before use.
package weld_seq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 4_000;
  localparam int LINE_PERIOD_US  = 16_667;
  localparam int LINE_CYC        = (LINE_PERIOD_US * 1_000
                                    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLASH_HALF_MS   = 250;
  localparam int FLASH_CYC       = FLASH_HALF_MS * 250_000;
  localparam int MSG_SHOW_MS     = 1_000;
  localparam int MSG_CYC         = MSG_SHOW_MS * 250_000;

  // ****************************************************************
  // Values and encodings
  // ****************************************************************
  localparam logic [1:0] BEAT_WAIT_OK  = 2'h3;
  localparam logic [6:0] HOLD_MARK     = 7'h63;
  localparam logic [6:0] SCH_B         = 7'h14;
  localparam logic [6:0] SCH_C         = 7'h28;
  localparam logic [6:0] SCH_D         = 7'h3c;
  localparam logic [2:0] MODE_WAIT     = 3'h4;
  localparam logic [1:0] KEY_FN_LOCK   = 2'h1;
  localparam logic [1:0] AIN2_FN_STACK = 2'h2;
  localparam logic [2:0] PH_SQUEEZE    = 3'h0;
  localparam logic [2:0] PH_WELD1      = 3'h1;
  localparam logic [2:0] PH_WELD2      = 3'h3;
  localparam logic [2:0] PH_LAST       = 3'h5;
  localparam logic [6:0] PIN_RST       = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b11
  } seq_state_e;

endpackage : weld_seq_pkg

// [core/pin_filter.sv]
// Three-flop filter for asynchronous pins.
// Assumes pins may change at any time relative to mclk_in.
`timescale 1ns/10ps
module pin_filter
  import weld_seq_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ****************************************************************
  // Filter: a change counts once stages two and three agree
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_r      <= '0;
      s2_r      <= '0;
      s3_r      <= '0;
      level_out <= '0;
    end
    else
    begin
      s1_r      <= pin_in;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
    end
  end

endmodule : pin_filter

// [core/weld_wait_hold_sequencer.sv]
// Weld sequencer with indefinite hold, edit lock gate and stack-up log.
// Assumes schedule data is looked up outside from sched_sel_out.
`timescale 1ns/10ps
// Function
// - Wait mode accepted only when beat config is 3
// - Run, stop at hold point, keep outputs
// - Hold point is the phase programmed 99
// - Estop or temp limit open aborts hold
// - Other initiation selects displayed, 20, 40, 60
// - Weld phase hold keeps current on
// - Lock active shows flashing lock indicator
// - Locked menu entry asks PIN; correct unlocks
// - Wrong PIN: view only, edits show message
// - Key acts as lock only when mapped
// - Stack-up logged only when input two mapped
module weld_wait_hold_sequencer
  import weld_seq_pkg::*;
#(
  parameter int TICK_CYC  = LINE_CYC,
  parameter int FLASH_CNT = FLASH_CYC,
  parameter int MSG_CNT   = MSG_CYC,
  parameter logic [6:0] PIN_CODE = 7'h2a  // Arbitrary value
)(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       initiation_input_a_in,
  input  wire logic       initiation_input_b_in,
  input  wire logic       initiation_input_c_in,
  input  wire logic       initiation_input_d_in,
  input  wire logic       estop_closed_in,
  input  wire logic       temp_closed_in,
  input  wire logic       lock_key_input_in,
  input  wire logic [1:0] key_func_in,
  input  wire logic [1:0] ain2_func_in,
  input  wire logic [1:0] beat_config_in,
  input  wire logic [6:0] displayed_sched_in,
  input  wire logic       mode_wr_in,
  input  wire logic [2:0] mode_wr_val_in,
  input  wire logic [2:0] cycle_mode_in,
  input  wire logic [2:0] valve_mask_in,
  input  wire logic [6:0] squeeze_in,
  input  wire logic [6:0] weld1_in,
  input  wire logic [6:0] cool1_in,
  input  wire logic [6:0] weld2_in,
  input  wire logic [6:0] cool2_in,
  input  wire logic [6:0] hold_in,
  input  wire logic       menu_req_in,
  input  wire logic       pin_enter_in,
  input  wire logic [6:0] pin_value_in,
  input  wire logic       edit_req_in,
  input  wire logic       weld_done_in,
  input  wire logic [15:0] stack_thick_in,
  input  wire logic [15:0] stack_disp_in,
  output logic [6:0]      sched_sel_out,
  output logic [2:0]      valve_out,
  output logic            weld_out,
  output logic            holding_out,
  output logic            mode_store_out,
  output logic            mode_refused_out,
  output logic            lock_indicator_out,
  output logic            pin_page_out,
  output logic            menu_open_out,
  output logic            edit_ok_out,
  output logic            edits_disabled_out,
  output logic            log_store_out,
  output logic [15:0]     log_thick_out,
  output logic [15:0]     log_disp_out
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (TICK_CYC < 1 || FLASH_CNT < 1 || MSG_CNT < 1)
  begin : g_bad_count
    $error("Counts must be at least one cycle");
  end

  // ****************************************************************
  // Pin filtering
  // ****************************************************************
  logic [6:0] pin_lvl;
  logic [3:0] init_prev_r;

  pin_filter #(
    .W         (7)
  ) u_pins (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    ({lock_key_input_in, temp_closed_in, estop_closed_in,
                 initiation_input_d_in, initiation_input_c_in,
                 initiation_input_b_in, initiation_input_a_in}),
    .level_out (pin_lvl)
  );

  wire [3:0] init_lvl  = pin_lvl[3:0];
  wire [3:0] init_rise = init_lvl & ~init_prev_r;
  wire       safe_ok   = pin_lvl[4] & pin_lvl[5];
  wire       any_init  = |init_rise;
  // Lowest input wins if two close in one cycle
  wire [6:0] init_sched = init_rise[0] ? displayed_sched_in :
                          init_rise[1] ? SCH_B :
                          init_rise[2] ? SCH_C : SCH_D;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  seq_state_e  state_r;
  seq_state_e  state_nxt;
  logic [2:0]  phase_r;
  logic [2:0]  phase_nxt;
  logic [6:0]  cnt_r;
  logic [6:0]  cnt_nxt;
  logic [31:0] tick_r;
  logic [2:0]  valve_nxt;
  logic        weld_nxt;
  logic [6:0]  sel_nxt;

  wire tick = (tick_r == 32'(TICK_CYC - 1));
  wire [6:0] ptime = (phase_r == 3'h0) ? squeeze_in :
                     (phase_r == 3'h1) ? weld1_in :
                     (phase_r == 3'h2) ? cool1_in :
                     (phase_r == 3'h3) ? weld2_in :
                     (phase_r == 3'h4) ? cool2_in : hold_in;
  wire hold_pt  = (ptime == HOLD_MARK)
                  && (cycle_mode_in == MODE_WAIT);
  wire weld_ph  = (phase_r == PH_WELD1) || (phase_r == PH_WELD2);
  wire ph_done  = (cnt_r == ptime);

  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    valve_nxt = valve_out;
    weld_nxt  = 1'b0;
    sel_nxt   = sched_sel_out;
    case (state_r)
      ST_IDLE:
        if (any_init && safe_ok)
        begin
          state_nxt = ST_RUN;
          phase_nxt = PH_SQUEEZE;
          cnt_nxt   = 7'h00;
          sel_nxt   = init_sched;
        end
      ST_RUN:
      begin
        valve_nxt = valve_mask_in;
        weld_nxt  = weld_ph;
        if (!safe_ok)
        begin
          state_nxt = ST_IDLE;
          valve_nxt = 3'h0;
          weld_nxt  = 1'b0;
        end
        else if (hold_pt)
          state_nxt = ST_HOLD;
        else if (ph_done)
        begin
          cnt_nxt = 7'h00;
          if (phase_r == PH_LAST)
          begin
            state_nxt = ST_IDLE;
            valve_nxt = 3'h0;
            weld_nxt  = 1'b0;
          end
          else
            phase_nxt = phase_r + 3'h1;
        end
        else if (tick)
          cnt_nxt = cnt_r + 7'h01;
      end
      ST_HOLD:
      begin
        valve_nxt = valve_mask_in;
        weld_nxt  = weld_ph;
        if (!safe_ok)
        begin
          state_nxt = ST_IDLE;
          valve_nxt = 3'h0;
          weld_nxt  = 1'b0;
        end
        else if (any_init)
        begin
          state_nxt = ST_RUN;
          phase_nxt = PH_SQUEEZE;
          cnt_nxt   = 7'h00;
          sel_nxt   = init_sched;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r       <= ST_IDLE;
      phase_r       <= PH_SQUEEZE;
      cnt_r         <= 7'h00;
      tick_r        <= 32'h0000_0000;
      valve_out     <= 3'h0;
      weld_out      <= 1'b0;
      sched_sel_out <= 7'h00;
      init_prev_r   <= 4'h0;
    end
    else
    begin
      state_r       <= state_nxt;
      phase_r       <= phase_nxt;
      cnt_r         <= cnt_nxt;
      tick_r        <= tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
      valve_out     <= valve_nxt;
      weld_out      <= weld_nxt;
      sched_sel_out <= sel_nxt;
      init_prev_r   <= init_lvl;
    end
  end

  assign holding_out = (state_r == ST_HOLD);

  // ****************************************************************
  // Cycle mode write gate
  // ****************************************************************
  // Wait mode is easy to misuse, so beat config acts as a second key
  wire mode_bad = (mode_wr_val_in == MODE_WAIT)
                  && (beat_config_in != BEAT_WAIT_OK);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_store_out   <= 1'b0;
      mode_refused_out <= 1'b0;
    end
    else
    begin
      mode_store_out   <= mode_wr_in & ~mode_bad;
      mode_refused_out <= mode_wr_in & mode_bad;
    end
  end

  // ****************************************************************
  // Edit lock
  // ****************************************************************
  logic        unlocked_r;
  logic        pin_wait_r;
  logic        flash_r;
  logic [31:0] flash_cnt_r;
  logic [31:0] msg_cnt_r;

  wire lock_on  = (key_func_in == KEY_FN_LOCK) & pin_lvl[6];
  wire locked   = lock_on & ~unlocked_r;
  wire pin_good = pin_enter_in & pin_wait_r & (pin_value_in == PIN_CODE);
  wire edit_go  = edit_req_in & menu_open_out & ~locked;
  wire edit_bad = edit_req_in & menu_open_out & locked;
  wire flash_wr = (flash_cnt_r == 32'(FLASH_CNT - 1));

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      unlocked_r         <= 1'b0;
      pin_wait_r         <= 1'b0;
      menu_open_out      <= 1'b0;
      edit_ok_out        <= 1'b0;
      edits_disabled_out <= 1'b0;
      msg_cnt_r          <= 32'h0000_0000;
      flash_r            <= 1'b0;
      flash_cnt_r        <= 32'h0000_0000;
      lock_indicator_out <= 1'b0;
    end
    else
    begin
      // Turning the key back re-arms the lock for the next session
      if (!lock_on)
        unlocked_r <= 1'b0;
      else if (pin_good)
        unlocked_r <= 1'b1;
      if (menu_req_in && !menu_open_out && locked)
        pin_wait_r <= 1'b1;
      else if (pin_enter_in)
        pin_wait_r <= 1'b0;
      if (menu_req_in && !locked)
        menu_open_out <= 1'b1;
      else if (pin_enter_in && pin_wait_r)
        menu_open_out <= 1'b1;
      edit_ok_out <= edit_go;
      if (edit_bad)
      begin
        edits_disabled_out <= 1'b1;
        msg_cnt_r          <= 32'(MSG_CNT - 1);
      end
      else if (msg_cnt_r != 32'h0000_0000)
        msg_cnt_r <= msg_cnt_r - 32'h0000_0001;
      else
        edits_disabled_out <= 1'b0;
      flash_cnt_r <= flash_wr ? 32'h0000_0000
                              : flash_cnt_r + 32'h0000_0001;
      if (flash_wr)
        flash_r <= ~flash_r;
      lock_indicator_out <= locked & flash_r;
    end
  end

  assign pin_page_out = pin_wait_r;

  // ****************************************************************
  // Stack-up logging
  // ****************************************************************
  wire log_go = weld_done_in & (ain2_func_in == AIN2_FN_STACK);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      log_store_out <= 1'b0;
      log_thick_out <= 16'h0000;
      log_disp_out  <= 16'h0000;
    end
    else
    begin
      log_store_out <= log_go;
      if (log_go)
      begin
        log_thick_out <= stack_thick_in;
        log_disp_out  <= stack_disp_in;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_wait_mode_gate: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) mode_wr_in && mode_wr_val_in == MODE_WAIT
    && beat_config_in != BEAT_WAIT_OK |=> !mode_store_out
    && mode_refused_out) else $error("Wait mode stored without beat 3");
  a_hold_keeps_valves: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) holding_out && safe_ok && !any_init
    |=> holding_out && valve_out == $past(valve_mask_in))
    else $error("Hold dropped or valves changed");
  a_hold_at_mark: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) $rose(holding_out) |-> $past(ptime) == HOLD_MARK)
    else $error("Hold entered at a phase not set to 99");
  a_safety_abort: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) holding_out && !safe_ok
    |=> state_r == ST_IDLE) else $error("Hold not aborted by safety");
  a_abort_clears: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) holding_out && !safe_ok
    |=> valve_out == 3'h0 && !weld_out) else $error("Outputs kept on abort");
  a_continue_sel: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) holding_out && safe_ok && init_rise == 4'h4
    |=> sched_sel_out == SCH_C && state_r == ST_RUN)
    else $error("Continue picked wrong schedule");
  a_weld_in_hold: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) holding_out && $past(holding_out) && weld_ph
    && $past(weld_ph) |-> weld_out) else $error("Weld dropped in hold");
  a_lock_flash: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) lock_indicator_out |-> $past(locked))
    else $error("Lock indicator without lock");
  a_pin_page: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) menu_req_in && !menu_open_out && locked
    |=> pin_page_out && !menu_open_out) else $error("No PIN page");
  a_edit_block: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) edit_req_in && menu_open_out && locked
    |=> !edit_ok_out && edits_disabled_out) else $error("Edit not blocked");
  a_key_mapping: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) key_func_in != KEY_FN_LOCK
    |=> !lock_indicator_out) else $error("Unmapped key locked edits");
  a_log_gate: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in) weld_done_in |=> log_store_out
    == ($past(ain2_func_in) == AIN2_FN_STACK)) else $error("Log gate wrong");

endmodule : weld_wait_hold_sequencer

// [verif/sched_table_model.sv]
// Stored-schedule table seen by the sequencer on the far side.
// Assumes a combinational lookup keyed by the running schedule number.
`timescale 1ns/10ps
module sched_table_model
  import weld_seq_pkg::*;
(
  input  wire logic [6:0]  sel_in,
  output logic      [2:0]  mode_out,
  output logic      [2:0]  valve_out,
  output logic      [41:0] phases_out
);
  // ****************************************************************
  // Table: phases packed as hold, cool2, weld2, cool1, weld1, squeeze
  // ****************************************************************
  // Schedule 22 marks squeeze 99 without the wait mode, so it must
  // run as an ordinary long time and never hold.
  always_comb
  begin
    case (sel_in)
      SCH_C:   {mode_out, valve_out, phases_out} =
        {MODE_WAIT, 3'h7, 14'h0000, HOLD_MARK, 14'h0000, 7'h03};
      SCH_D:   {mode_out, valve_out, phases_out} =
        {3'h0, 3'h7, 7'h02, 28'h000_0000, 7'h01};
      7'h15:   {mode_out, valve_out, phases_out} =
        {MODE_WAIT, 3'h3, HOLD_MARK, 28'h000_0000, 7'h02};
      7'h16:   {mode_out, valve_out, phases_out} =
        {3'h0, 3'h1, 35'h0_0000_0000, HOLD_MARK};
      default: {mode_out, valve_out, phases_out} =
        {3'h0, 3'h1, 14'h0000, 7'h01, 14'h0000, 7'h02};
    endcase
  end
endmodule : sched_table_model

// [verif/weld_wait_hold_sequencer_tb.sv]
// Self-checking bench for the weld wait-hold sequencer.
// Assumes the schedule table model answers within the same cycle.
`timescale 1ns/10ps
module weld_wait_hold_sequencer_tb;
  import weld_seq_pkg::*;
  localparam logic [6:0] PIN_OK = 7'h2a;  // Arbitrary value
  logic        clk = 1'h0, rst_n = 1'h0, key = 1'h0, done = 1'h0;
  logic        estop = 1'h1, temp = 1'h1, mode_wr = 1'h0, menu = 1'h0;
  logic        pin_en = 1'h0, edit = 1'h0;
  logic [3:0]  init = 4'h0;
  logic [1:0]  key_fn = 2'h0, ain2 = 2'h0, beat = 2'h0;
  logic [2:0]  mode_val = 3'h0, mode, vmask, valve;
  logic [6:0]  pin = 7'h00, disp = 7'h15, sel;
  logic [41:0] ph;
  logic [15:0] thick = 16'h0123, dsp = 16'h0456, l_thick, l_disp;
  logic        weld, holding, m_st, m_rf, lk, pg, mopen, e_ok, e_dis, lg;
  int          miscompares = 0, total_checks = 0, cyc = 0, n;

  // ****************************************************************
  // Design and far side
  // ****************************************************************
  weld_wait_hold_sequencer #(.TICK_CYC(4), .FLASH_CNT(8), .MSG_CNT(16),
    .PIN_CODE(PIN_OK)) DUT (
    .mclk_in(clk), .rst_n_in(rst_n),
    .initiation_input_a_in(init[0]), .initiation_input_b_in(init[1]),
    .initiation_input_c_in(init[2]), .initiation_input_d_in(init[3]),
    .estop_closed_in(estop), .temp_closed_in(temp),
    .lock_key_input_in(key), .key_func_in(key_fn), .ain2_func_in(ain2),
    .beat_config_in(beat), .displayed_sched_in(disp),
    .mode_wr_in(mode_wr), .mode_wr_val_in(mode_val),
    .cycle_mode_in(mode), .valve_mask_in(vmask),
    .squeeze_in(ph[6:0]), .weld1_in(ph[13:7]), .cool1_in(ph[20:14]),
    .weld2_in(ph[27:21]), .cool2_in(ph[34:28]), .hold_in(ph[41:35]),
    .menu_req_in(menu), .pin_enter_in(pin_en), .pin_value_in(pin),
    .edit_req_in(edit), .weld_done_in(done),
    .stack_thick_in(thick), .stack_disp_in(dsp),
    .sched_sel_out(sel), .valve_out(valve), .weld_out(weld),
    .holding_out(holding), .mode_store_out(m_st),
    .mode_refused_out(m_rf), .lock_indicator_out(lk),
    .pin_page_out(pg), .menu_open_out(mopen), .edit_ok_out(e_ok),
    .edits_disabled_out(e_dis), .log_store_out(lg),
    .log_thick_out(l_thick), .log_disp_out(l_disp));
  sched_table_model far_side (.sel_in(sel), .mode_out(mode),
    .valve_out(vmask), .phases_out(ph));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  always #2 clk = ~clk;

  // Ceiling sits well above the few hundred cycles the tests take
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20_000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [39:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  // Inputs always change one ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic do_reset();
    rst_n = 1'h0;
    tick(20);
    rst_n = 1'h1;
    tick(5);
  endtask : do_reset

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask : pulse

  // Pins pass a three-flop filter, so closures last well past it
  task automatic fire(input int i);
    init[i] = 1'h1;
    tick(8);
    init[i] = 1'h0;
    tick(5);
  endtask : fire

  function automatic logic probe(input int k);
    case (k)
      0:       return holding;
      1:       return valve == 3'h0 && !weld && !holding;
      default: return mopen;
    endcase
  endfunction : probe

  task automatic wait_for(input int k, input int lim, input string msg);
    int c;
    c = 0;
    while (probe(k) !== 1'h1 && c < lim)
    begin
      tick(1);
      c++;
    end
    check(probe(k), 1'h1, msg);
  endtask : wait_for

  task automatic count_lock(input int k);
    n = 0;
    repeat (k)
    begin
      tick(1);
      n += (lk === 1'h1);
    end
  endtask : count_lock

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    do_reset();
    for (int i = 0; i < 3; i++)
    begin
      beat = (i == 1) ? BEAT_WAIT_OK : 2'h2;
      mode_val = (i == 2) ? 3'h1 : MODE_WAIT;
      pulse(mode_wr);
      check({m_st, m_rf}, (i == 0) ? 2'h1 : 2'h2, "mode write");
      tick(1);
    end
    fire(2);
    wait_for(0, 100, "weld2 hold");
    tick(60);
    check({sel, valve, weld, holding}, {SCH_C, 4'hf, 1'h1}, "weld");
    fire(1);
    check(sel, SCH_B, "second input");
    wait_for(1, 100, "run end");
    fire(0);
    wait_for(0, 100, "hold phase");
    check({sel, valve, weld}, {disp, 4'h6}, "displayed");
    fire(2);
    check(sel, SCH_C, "third input");
    wait_for(0, 100, "c hold again");
    fire(3);
    check(sel, SCH_D, "fourth input");
    wait_for(1, 100, "d end");
    for (int s = 0; s < 2; s++)
    begin
      fire(0);
      wait_for(0, 100, "hold again");
      if (s == 0)
        estop = 1'h0;
      else
        temp = 1'h0;
      wait_for(1, 12, "abort");
      estop = 1'h1;
      temp = 1'h1;
      tick(6);
    end
    disp = 7'h16;
    fire(0);
    tick(40);
    check({holding, valve}, 4'h1, "99 without wait");
    estop = 1'h0;
    wait_for(1, 12, "abort run");
    estop = 1'h1;
    for (int i = 0; i < 2; i++)
    begin
      ain2 = (i == 0) ? AIN2_FN_STACK : 2'h1;
      pulse(done);
      check(lg, (i == 0), "log store");
      tick(1);
    end
    check({l_thick, l_disp}, {thick, dsp}, "log data");
    key_fn = KEY_FN_LOCK;
    key = 1'h1;
    tick(10);
    count_lock(40);
    check(n >= 16 && n <= 24, 1'h1, "flash");
    pulse(menu);
    check({pg, mopen}, 2'h2, "pin page");
    pin = 7'h11;
    pulse(pin_en);
    check({pg, mopen}, 2'h1, "wrong pin menu");
    pulse(edit);
    check({e_ok, e_dis}, 2'h1, "edit blocked");
    tick(20);
    check(e_dis, 1'h0, "message ends");
    do_reset();
    pulse(menu);
    pin = PIN_OK;
    pulse(pin_en);
    pulse(edit);
    check({e_ok, e_dis}, 2'h2, "unlocked edit");
    do_reset();
    key_fn = 2'h2;
    count_lock(40);
    check(n, 0, "no flash unmapped");
    pulse(menu);
    wait_for(2, 5, "menu unmapped");
    pulse(edit);
    check({e_ok, e_dis}, 2'h2, "edit unmapped");
    report_and_stop();
  end
endmodule : weld_wait_hold_sequencer_tb
